// >>> logic/cmg_pkg.sv
package cmg_pkg;
	// CPU modes, one-hot
	typedef enum logic [4:0] {
		CMG_MODE_BOOT = 5'h01,
		CMG_MODE_TEST = 5'h02,
		CMG_MODE_FW = 5'h04,
		CMG_MODE_SYS = 5'h08,
		CMG_MODE_USER = 5'h10
	} cmg_mode_e;

	localparam int CMG_AW = 16;
	localparam int CMG_DW = 8;

	// Mode field encoding in the control/status register (2 bits)
	localparam logic [1:0] CMG_CSR_USER = 2'h0;
	localparam logic [1:0] CMG_CSR_SYS = 2'h1;
	localparam logic [1:0] CMG_CSR_FW = 2'h2;
	localparam int CMG_CSR_MODE_LSB = 0;

	// Register addresses in the special function space
	localparam logic [CMG_AW-1:0] CMG_ADR_CSR = 16'h0000;
	localparam logic [CMG_AW-1:0] CMG_ADR_STBL_LO = 16'h0010;
	localparam logic [CMG_AW-1:0] CMG_ADR_STBL_HI = 16'h0011;
	localparam logic [CMG_AW-1:0] CMG_ADR_XBASE = 16'h0012;
	localparam logic [CMG_AW-1:0] CMG_ADR_XSIZE = 16'h0013;
	localparam logic [CMG_AW-1:0] CMG_ADR_FEAT_TMP = 16'h0020;

	// Fixed memory partition: firmware NVM region and application split
	localparam logic [CMG_AW-1:0] CMG_NVM_BASE = 16'h8000;
	localparam logic [CMG_AW-1:0] CMG_FW_NVM_LO = 16'h8000;
	localparam logic [CMG_AW-1:0] CMG_FW_NVM_HI = 16'h82FF;
	localparam logic [CMG_AW-1:0] CMG_FW_RAM_HI = 16'h01FF;
	localparam logic [CMG_AW-1:0] CMG_RAM_HI = 16'h1FFF;

	// Mode change entry addresses
	localparam logic [CMG_AW-1:0] CMG_SYSCALL_ADDR = 16'h0100;
	localparam logic [CMG_AW-1:0] CMG_FWENTRY_ADDR = 16'h0200;

	// Reset values
	localparam logic [CMG_DW-1:0] CMG_STBL_RST = 8'h00;
	localparam logic [3:0] CMG_FEAT_RST = 4'h0;
	localparam int CMG_NFEAT = 4;
endpackage : cmg_pkg

// >>> logic/cmg_copy_mode.sv
`timescale 1ns/1ps
// Latches the CPU mode when a block copy starts and holds it until done
module cmg_copy_mode (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_start,
	input wire logic i_done,
	input wire cmg_pkg::cmg_mode_e i_mode,
	output logic o_busy,
	output cmg_pkg::cmg_mode_e o_mode
);
	// Mode captured at start is immune to later mode changes
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_busy <= 1'b0;
			o_mode <= cmg_pkg::CMG_MODE_USER;
		end else if (i_start && !o_busy) begin
			o_busy <= 1'b1;
			o_mode <= i_mode;
		end else if (i_done) begin
			o_busy <= 1'b0;
		end
	end

	a_copy_mode_held : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_busy && $past(o_busy) |-> o_mode == $past(o_mode))
		else $error("copy mode changed during copy");
endmodule : cmg_copy_mode

// >>> logic/cmg_access_guard.sv
`timescale 1ns/1ps
module cmg_access_guard (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Boot done and test entry from the system controller
	input wire logic i_boot_done,
	input wire logic i_test_entry,
	// Memory access from CPU
	input wire logic i_mem_req,
	input wire logic i_mem_wr,
	input wire logic [cmg_pkg::CMG_AW-1:0] i_mem_addr,
	input wire logic i_mem_integrity, // Firmware integrity check access
	input wire logic i_seg_wr_ok, // Segment table grants write (user)
	input wire logic i_seg_rd_ok, // Segment table grants read (user)
	// Special function register writes from CPU
	input wire logic i_sfr_wr,
	input wire logic [cmg_pkg::CMG_AW-1:0] i_sfr_addr,
	input wire logic [cmg_pkg::CMG_DW-1:0] i_sfr_wdata,
	// Mode change events
	input wire logic i_call,
	input wire logic i_long_call,
	input wire logic [cmg_pkg::CMG_AW-1:0] i_call_target,
	input wire logic i_irq_take,
	input wire logic i_irq_return,
	// Permanent feature disable (fuse writes, accepted and overwritten in boot or test mode)
	input wire logic i_perm_wr,
	input wire logic [3:0] i_perm_data,
	// Copy engine
	input wire logic i_copy_start,
	input wire logic i_copy_done,
	output logic o_mem_grant,
	output logic o_mem_deny,
	output logic o_sfr_deny,
	output logic [4:0] o_mode,
	output logic [2*cmg_pkg::CMG_DW-1:0] o_stbl_base,
	output logic [cmg_pkg::CMG_DW-1:0] o_xchg_base,
	output logic [cmg_pkg::CMG_DW-1:0] o_xchg_size,
	output logic [3:0] o_feat_en,
	output logic o_copy_busy,
	output logic [4:0] o_copy_mode
);
	localparam int DEPTH = 4; // Saved-mode stack for nested interrupts

	cmg_pkg::cmg_mode_e mode;
	cmg_pkg::cmg_mode_e next_mode;
	cmg_pkg::cmg_mode_e copy_mode;
	cmg_pkg::cmg_mode_e stack [DEPTH];
	logic [2:0] sp;
	logic [3:0] feat_tmp;
	logic [3:0] feat_perm;
	logic copy_busy;
	logic sfr_ok;
	logic mem_ok;

	function automatic logic is_seg_reg(input logic [cmg_pkg::CMG_AW-1:0] a);
		is_seg_reg = (a == cmg_pkg::CMG_ADR_STBL_LO) || (a == cmg_pkg::CMG_ADR_STBL_HI)
			|| (a == cmg_pkg::CMG_ADR_XBASE) || (a == cmg_pkg::CMG_ADR_XSIZE);
	endfunction : is_seg_reg

	function automatic cmg_pkg::cmg_mode_e csr_mode(input logic [1:0] f);
		if (f == cmg_pkg::CMG_CSR_SYS) begin
			csr_mode = cmg_pkg::CMG_MODE_SYS;
		end else if (f == cmg_pkg::CMG_CSR_FW) begin
			csr_mode = cmg_pkg::CMG_MODE_FW;
		end else begin
			csr_mode = cmg_pkg::CMG_MODE_USER;
		end
	endfunction : csr_mode

	////////////////////////////////////////////////////////////////////////////
	// SFR write permission per mode
	always_comb begin
		sfr_ok = 1'b0;
		if (is_seg_reg(i_sfr_addr)) begin
			sfr_ok = (mode == cmg_pkg::CMG_MODE_SYS);
		end else if (i_sfr_addr == cmg_pkg::CMG_ADR_CSR) begin
			sfr_ok = (mode == cmg_pkg::CMG_MODE_SYS) || (mode == cmg_pkg::CMG_MODE_TEST);
		end else if (i_sfr_addr == cmg_pkg::CMG_ADR_FEAT_TMP) begin
			sfr_ok = (mode != cmg_pkg::CMG_MODE_USER);
		end
	end

	// Memory permission; partition bounds are constants, only the firmware exchange window moves with its registers
	always_comb begin
		mem_ok = 1'b0;
		case (mode)
			cmg_pkg::CMG_MODE_BOOT, cmg_pkg::CMG_MODE_TEST: begin
				mem_ok = 1'b1;
			end
			cmg_pkg::CMG_MODE_FW: begin
				if (i_mem_addr >= cmg_pkg::CMG_NVM_BASE) begin
					mem_ok = i_mem_integrity
						|| (i_mem_addr >= cmg_pkg::CMG_FW_NVM_LO
						&& i_mem_addr <= cmg_pkg::CMG_FW_NVM_HI);
				end else begin
					mem_ok = (i_mem_addr <= cmg_pkg::CMG_FW_RAM_HI)
						|| (i_mem_addr[cmg_pkg::CMG_AW-1:8] >= {8'h00, o_xchg_base}
						&& i_mem_addr[cmg_pkg::CMG_AW-1:8] < {8'h00, o_xchg_base} + {8'h00, o_xchg_size});
				end
			end
			cmg_pkg::CMG_MODE_SYS: begin
				// Firmware region is closed to application code
				mem_ok = !(i_mem_addr >= cmg_pkg::CMG_FW_NVM_LO
					&& i_mem_addr <= cmg_pkg::CMG_FW_NVM_HI)
					&& !(i_mem_addr <= cmg_pkg::CMG_FW_RAM_HI);
			end
			cmg_pkg::CMG_MODE_USER: begin
				// Table itself gets no special guard; segments decide
				mem_ok = (o_stbl_base != 16'h0000)
					&& (i_mem_wr ? i_seg_wr_ok : i_seg_rd_ok)
					&& !(i_mem_addr >= cmg_pkg::CMG_FW_NVM_LO
					&& i_mem_addr <= cmg_pkg::CMG_FW_NVM_HI)
					&& !(i_mem_addr <= cmg_pkg::CMG_FW_RAM_HI);
			end
			default: begin
				mem_ok = 1'b0;
			end
		endcase
	end

	// Registered grant or deny, one cycle after the request
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_mem_grant <= 1'b0;
			o_mem_deny <= 1'b0;
			o_sfr_deny <= 1'b0;
		end else begin
			o_mem_grant <= i_mem_req && mem_ok;
			o_mem_deny <= i_mem_req && !mem_ok;
			o_sfr_deny <= i_sfr_wr && !sfr_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Segmentation registers: zero at reset so no user segment exists
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_stbl_base <= {cmg_pkg::CMG_STBL_RST, cmg_pkg::CMG_STBL_RST};
			o_xchg_base <= cmg_pkg::CMG_STBL_RST;
			o_xchg_size <= cmg_pkg::CMG_STBL_RST;
		end else if (i_sfr_wr && sfr_ok) begin
			if (i_sfr_addr == cmg_pkg::CMG_ADR_STBL_LO) begin
				o_stbl_base[7:0] <= i_sfr_wdata;
			end else if (i_sfr_addr == cmg_pkg::CMG_ADR_STBL_HI) begin
				o_stbl_base[15:8] <= i_sfr_wdata;
			end else if (i_sfr_addr == cmg_pkg::CMG_ADR_XBASE) begin
				o_xchg_base <= i_sfr_wdata;
			end else if (i_sfr_addr == cmg_pkg::CMG_ADR_XSIZE) begin
				o_xchg_size <= i_sfr_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next CPU mode from the mode-change events, by priority
	always_comb begin
		next_mode = mode;
		if (mode == cmg_pkg::CMG_MODE_BOOT) begin
			if (i_test_entry) begin
				next_mode = cmg_pkg::CMG_MODE_TEST;
			end else if (i_boot_done) begin
				next_mode = cmg_pkg::CMG_MODE_SYS;
			end
		end else if (i_irq_take) begin
			next_mode = cmg_pkg::CMG_MODE_SYS;
		end else if (i_irq_return && sp != 3'h0) begin
			next_mode = stack[sp[1:0] - 2'h1];
		end else if ((i_call || i_long_call) && i_call_target == cmg_pkg::CMG_SYSCALL_ADDR) begin
			next_mode = cmg_pkg::CMG_MODE_SYS;
		end else if ((i_call || i_long_call) && i_call_target == cmg_pkg::CMG_FWENTRY_ADDR) begin
			next_mode = cmg_pkg::CMG_MODE_FW;
		end else if (i_sfr_wr && sfr_ok && i_sfr_addr == cmg_pkg::CMG_ADR_CSR) begin
			next_mode = csr_mode(i_sfr_wdata[cmg_pkg::CMG_CSR_MODE_LSB +: 2]);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode <= cmg_pkg::CMG_MODE_BOOT;
		end else begin
			mode <= next_mode;
		end
	end

	// Saved-mode stack; a full stack drops the newest level's save
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sp <= 3'h0;
			for (int i = 0; i < DEPTH; i++) begin
				stack[i] <= cmg_pkg::CMG_MODE_SYS;
			end
		end else if (mode != cmg_pkg::CMG_MODE_BOOT && i_irq_take) begin
			if (sp != 3'(DEPTH)) begin
				stack[sp[1:0]] <= mode;
				sp <= sp + 3'h1;
			end
		end else if (mode != cmg_pkg::CMG_MODE_BOOT && i_irq_return && sp != 3'h0) begin
			sp <= sp - 3'h1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_mode <= cmg_pkg::CMG_MODE_BOOT;
		end else begin
			o_mode <= next_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Feature enables: temporary bits and permanent disables that boot or test mode can rewrite
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			feat_tmp <= cmg_pkg::CMG_FEAT_RST;
		end else if (i_sfr_wr && sfr_ok && i_sfr_addr == cmg_pkg::CMG_ADR_FEAT_TMP) begin
			feat_tmp <= i_sfr_wdata[3:0];
		end
	end

	// Permanent state follows a privileged fuse write; survives only reset-free
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			feat_perm <= cmg_pkg::CMG_FEAT_RST;
		end else if (i_perm_wr && (mode == cmg_pkg::CMG_MODE_TEST || mode == cmg_pkg::CMG_MODE_BOOT)) begin
			feat_perm <= i_perm_data;
		end
	end

	// Bit set means disabled, either way
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_feat_en <= ~cmg_pkg::CMG_FEAT_RST;
		end else begin
			o_feat_en <= ~(feat_tmp | feat_perm);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Copy engine mode hold
	cmg_copy_mode u_copy (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_start(i_copy_start),
		.i_done(i_copy_done),
		.i_mode(mode),
		.o_busy(copy_busy),
		.o_mode(copy_mode)
	);

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_copy_busy <= 1'b0;
			o_copy_mode <= cmg_pkg::CMG_MODE_USER;
		end else begin
			o_copy_busy <= copy_busy;
			o_copy_mode <= copy_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_seg_sys_only : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_sfr_wr && is_seg_reg(i_sfr_addr) && mode != cmg_pkg::CMG_MODE_SYS
		|=> o_sfr_deny && $stable(o_stbl_base) && $stable(o_xchg_base))
		else $error("segmentation register written outside system mode");
	a_user_no_seg : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_sfr_wr && i_sfr_addr == cmg_pkg::CMG_ADR_STBL_HI && mode == cmg_pkg::CMG_MODE_USER
		|=> $stable(o_stbl_base))
		else $error("user moved segment table pointer");
	a_fw_firewall : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_mem_req && mode == cmg_pkg::CMG_MODE_FW && !i_mem_integrity
		&& i_mem_addr > cmg_pkg::CMG_FW_NVM_HI |=> o_mem_deny)
		else $error("firmware escaped its region");
	a_fw_integrity : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_mem_req && mode == cmg_pkg::CMG_MODE_FW && i_mem_integrity
		&& i_mem_addr >= cmg_pkg::CMG_NVM_BASE |=> o_mem_grant)
		else $error("integrity access refused");
	a_user_no_fw : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_mem_req && mode == cmg_pkg::CMG_MODE_USER && i_mem_addr <= cmg_pkg::CMG_FW_RAM_HI
		|=> o_mem_deny)
		else $error("user reached firmware area");
	a_user_seg_wr : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_mem_req && i_mem_wr && mode == cmg_pkg::CMG_MODE_USER && !i_seg_wr_ok
		|=> !o_mem_grant)
		else $error("user write without segment permission");
	a_irq_sys : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_irq_take && mode != cmg_pkg::CMG_MODE_BOOT |=> o_mode == cmg_pkg::CMG_MODE_SYS)
		else $error("interrupt did not enter system mode");
	// Exactly one quiet cycle sits between entry and return; the saved level is untouched
	a_irq_ret_restore : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		mode == cmg_pkg::CMG_MODE_USER && i_irq_take && sp == 3'h0
		##1 (!i_irq_take && !i_irq_return) ##1 (!i_irq_take && i_irq_return)
		|=> mode == cmg_pkg::CMG_MODE_USER)
		else $error("return did not restore mode");
	a_fw_entry : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		mode == cmg_pkg::CMG_MODE_SYS && !i_irq_take && !i_irq_return && i_call
		&& i_call_target == cmg_pkg::CMG_FWENTRY_ADDR |=> mode == cmg_pkg::CMG_MODE_FW)
		else $error("firmware entry ignored");
	// Write data is gone by the time the enable shows, so look back to it
	a_feat_disable : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_sfr_wr && sfr_ok && i_sfr_addr == cmg_pkg::CMG_ADR_FEAT_TMP
		|=> ##1 o_feat_en[0] == !($past(i_sfr_wdata[0], 2) || $past(feat_perm[0])))
		else $error("feature enable mismatch");
endmodule : cmg_access_guard

// >>> bench/cmg_cpu_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// CPU core stand-in: each call raises one request just after an edge and
// holds it for exactly one sampling edge, as the guard takes it
module cmg_cpu_model (
	input wire logic i_sys_clk,
	output logic o_boot_done,
	output logic o_test_entry,
	output logic o_mem_req,
	output logic o_mem_wr,
	output logic [cmg_pkg::CMG_AW-1:0] o_mem_addr,
	output logic o_mem_integrity,
	output logic o_seg_wr_ok,
	output logic o_seg_rd_ok,
	output logic o_sfr_wr,
	output logic [cmg_pkg::CMG_AW-1:0] o_sfr_addr,
	output logic [cmg_pkg::CMG_DW-1:0] o_sfr_wdata,
	output logic o_call,
	output logic o_long_call,
	output logic [cmg_pkg::CMG_AW-1:0] o_call_target,
	output logic o_irq_take,
	output logic o_irq_return,
	output logic o_perm_wr,
	output logic [3:0] o_perm_data,
	output logic o_copy_start,
	output logic o_copy_done
);
	logic [8:0] ev;
	// Event strobes share one vector so a single task drives any of them
	assign {o_boot_done, o_test_entry, o_call, o_long_call, o_irq_take} = ev[8:4];
	assign {o_irq_return, o_perm_wr, o_copy_start, o_copy_done} = ev[3:0];
	// All lines quiet at time zero
	initial begin
		ev = '0;
		{o_mem_req, o_mem_wr, o_mem_integrity, o_seg_wr_ok, o_seg_rd_ok} = '0;
		{o_mem_addr, o_sfr_wr, o_sfr_addr, o_sfr_wdata} = '0;
		{o_call_target, o_perm_data} = '0;
	end
	////////////////////////////////////////////////////////////////////////////
	// Released lines show the inverse, so a stale value is never mistaken
	task automatic sfr_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_sys_clk) #1;
		o_sfr_wr = 1'b1;
		o_sfr_addr = a;
		o_sfr_wdata = d;
		@(posedge i_sys_clk) #1;
		o_sfr_wr = 1'b0;
		o_sfr_addr = ~a;
		o_sfr_wdata = ~d;
	endtask : sfr_write
	task automatic mem_access(input logic [3:0] f, input logic [15:0] a);
		@(posedge i_sys_clk) #1;
		o_mem_req = 1'b1;
		{o_mem_wr, o_mem_integrity, o_seg_wr_ok, o_seg_rd_ok} = f;
		o_mem_addr = a;
		@(posedge i_sys_clk) #1;
		o_mem_req = 1'b0;
		{o_mem_wr, o_mem_integrity, o_seg_wr_ok, o_seg_rd_ok} = ~f;
		o_mem_addr = ~a;
	endtask : mem_access
	task automatic fire(input logic [8:0] k, input logic [15:0] t, input logic [3:0] p);
		@(posedge i_sys_clk) #1;
		ev = k;
		o_call_target = t;
		o_perm_data = p;
		@(posedge i_sys_clk) #1;
		ev = '0;
		o_call_target = ~t;
		o_perm_data = ~p;
	endtask : fire
endmodule : cmg_cpu_model

// >>> bench/cmg_access_guard_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) check_val(16'(g), 16'(e))
module cmg_access_guard_tb_top;
	logic i_sys_clk, i_reset_n, i_boot_done, i_test_entry, i_mem_req, i_mem_wr;
	logic i_mem_integrity, i_seg_wr_ok, i_seg_rd_ok, i_sfr_wr, i_call, i_long_call;
	logic i_irq_take, i_irq_return, i_perm_wr, i_copy_start, i_copy_done;
	logic [15:0] i_mem_addr, i_sfr_addr, i_call_target, o_stbl_base;
	logic [7:0] i_sfr_wdata, o_xchg_base, o_xchg_size;
	logic [3:0] i_perm_data, o_feat_en;
	logic [4:0] o_mode, o_copy_mode;
	logic o_mem_grant, o_mem_deny, o_sfr_deny, o_copy_busy;
	int failures = 0;
	int total_checks = 0;
	localparam logic [8:0] BOOT = 9'h100, TEST = 9'h080, CALL = 9'h040, LONG_CALL = 9'h020;
	localparam logic [8:0] IRQ = 9'h010, IRQ_RET = 9'h008, PERM = 9'h004;
	localparam logic [8:0] CST = 9'h002, CDN = 9'h001;
	localparam logic [15:0] SYSA = cmg_pkg::CMG_SYSCALL_ADDR;
	localparam logic [15:0] LO = cmg_pkg::CMG_ADR_STBL_LO, HI = cmg_pkg::CMG_ADR_STBL_HI;
	localparam logic [15:0] CSR = cmg_pkg::CMG_ADR_CSR, FEAT = cmg_pkg::CMG_ADR_FEAT_TMP;

	cmg_access_guard u_dut (.i_sys_clk, .i_reset_n, .i_boot_done, .i_test_entry,
		.i_mem_req, .i_mem_wr, .i_mem_addr, .i_mem_integrity, .i_seg_wr_ok, .i_seg_rd_ok,
		.i_sfr_wr, .i_sfr_addr, .i_sfr_wdata, .i_call, .i_long_call, .i_call_target,
		.i_irq_take, .i_irq_return, .i_perm_wr, .i_perm_data, .i_copy_start, .i_copy_done,
		.o_mem_grant, .o_mem_deny, .o_sfr_deny, .o_mode, .o_stbl_base, .o_xchg_base,
		.o_xchg_size, .o_feat_en, .o_copy_busy, .o_copy_mode);
	cmg_cpu_model u_cpu (.i_sys_clk, .o_boot_done(i_boot_done), .o_test_entry(i_test_entry),
		.o_mem_req(i_mem_req), .o_mem_wr(i_mem_wr), .o_mem_addr(i_mem_addr),
		.o_mem_integrity(i_mem_integrity), .o_seg_wr_ok(i_seg_wr_ok),
		.o_seg_rd_ok(i_seg_rd_ok), .o_sfr_wr(i_sfr_wr), .o_sfr_addr(i_sfr_addr),
		.o_sfr_wdata(i_sfr_wdata), .o_call(i_call), .o_long_call(i_long_call),
		.o_call_target(i_call_target), .o_irq_take(i_irq_take),
		.o_irq_return(i_irq_return),
		.o_perm_wr(i_perm_wr), .o_perm_data(i_perm_data), .o_copy_start(i_copy_start),
		.o_copy_done(i_copy_done));
	////////////////////////////////////////////////////////////////////////////
	// Free-running 100 MHz clock
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// Case equality so an unknown output never counts as a match
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic do_reset();
		i_reset_n = 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1 i_reset_n = 1'b1;
	endtask : do_reset
	task automatic wait_cycle();
		@(posedge i_sys_clk) #1;
	endtask : wait_cycle
	////////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole sequence needs well under two hundred cycles
	initial begin
		#20000;
		failures++;
		complete_run();
	end
	initial begin
		do_reset();
		`CHK(o_mode, cmg_pkg::CMG_MODE_BOOT);
		`CHK(o_stbl_base, 16'h0000);
		`CHK({o_xchg_base, o_xchg_size}, 16'h0000);
		`CHK(o_feat_en, 4'hF);
		`CHK({o_copy_busy, o_copy_mode}, cmg_pkg::CMG_MODE_USER);
		u_cpu.sfr_write(LO, 8'h5A);
		`CHK(o_sfr_deny, 1'b1);
		`CHK(o_stbl_base, 16'h0000);
		$display("test reset_and_boot done");
		u_cpu.fire(BOOT, 16'h0000, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_SYS);
		u_cpu.sfr_write(LO, 8'h34);
		`CHK(o_sfr_deny, 1'b0);
		u_cpu.sfr_write(HI, 8'h12);
		`CHK(o_stbl_base, 16'h1234);
		u_cpu.sfr_write(cmg_pkg::CMG_ADR_XBASE, 8'h40);
		u_cpu.sfr_write(cmg_pkg::CMG_ADR_XSIZE, 8'h02);
		`CHK({o_xchg_base, o_xchg_size}, 16'h4002);
		u_cpu.sfr_write(FEAT, 8'h05);
		wait_cycle();
		`CHK(o_feat_en, 4'hA);
		u_cpu.sfr_write(FEAT, 8'h00);
		wait_cycle();
		`CHK(o_feat_en, 4'hF);
		$display("test system_config done");
		u_cpu.sfr_write(CSR, 8'(cmg_pkg::CMG_CSR_USER));
		`CHK(o_mode, cmg_pkg::CMG_MODE_USER);
		u_cpu.sfr_write(HI, 8'h00);
		`CHK(o_sfr_deny, 1'b1);
		`CHK(o_stbl_base, 16'h1234);
		u_cpu.sfr_write(CSR, 8'(cmg_pkg::CMG_CSR_SYS));
		`CHK(o_mode, cmg_pkg::CMG_MODE_USER);
		u_cpu.sfr_write(FEAT, 8'h0F);
		wait_cycle();
		`CHK(o_feat_en, 4'hF);
		// Flags: write, integrity, segment write ok, segment read ok
		u_cpu.mem_access(4'b1010, 16'h1000);
		`CHK({o_mem_grant, o_mem_deny}, 2'b10);
		u_cpu.mem_access(4'b1001, 16'h1000);
		`CHK({o_mem_grant, o_mem_deny}, 2'b01);
		u_cpu.mem_access(4'b0011, 16'h0100);
		`CHK({o_mem_grant, o_mem_deny}, 2'b01);
		u_cpu.mem_access(4'b0011, 16'h8100);
		`CHK({o_mem_grant, o_mem_deny}, 2'b01);
		$display("test user_limits done");
		u_cpu.fire(IRQ, 16'h0000, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_SYS);
		u_cpu.fire(IRQ_RET, 16'h0000, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_USER);
		u_cpu.fire(CALL, SYSA, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_SYS);
		u_cpu.sfr_write(CSR, 8'(cmg_pkg::CMG_CSR_USER));
		u_cpu.fire(LONG_CALL, SYSA, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_SYS);
		u_cpu.sfr_write(CSR, 8'(cmg_pkg::CMG_CSR_FW));
		`CHK(o_mode, cmg_pkg::CMG_MODE_FW);
		u_cpu.fire(CALL, SYSA, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_SYS);
		// System code is kept out of the firmware region but reaches its own NVM
		u_cpu.mem_access(4'b0011, 16'h8100);
		`CHK({o_mem_grant, o_mem_deny}, 2'b01);
		u_cpu.mem_access(4'b0011, 16'h9000);
		`CHK({o_mem_grant, o_mem_deny}, 2'b10);
		u_cpu.fire(CALL, cmg_pkg::CMG_FWENTRY_ADDR, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_FW);
		$display("test mode_events done");
		u_cpu.mem_access(4'b1000, 16'h8100);
		`CHK({o_mem_grant, o_mem_deny}, 2'b10);
		u_cpu.mem_access(4'b1000, 16'h9000);
		`CHK({o_mem_grant, o_mem_deny}, 2'b01);
		u_cpu.mem_access(4'b1100, 16'h9000);
		`CHK({o_mem_grant, o_mem_deny}, 2'b10);
		// Exchange window is pages 0x40 and 0x41, set from system mode above
		u_cpu.mem_access(4'b0000, 16'h4100);
		`CHK({o_mem_grant, o_mem_deny}, 2'b10);
		u_cpu.mem_access(4'b0000, 16'h4200);
		`CHK({o_mem_grant, o_mem_deny}, 2'b01);
		u_cpu.sfr_write(LO, 8'h00);
		`CHK(o_sfr_deny, 1'b1);
		u_cpu.fire(CST, 16'h0000, 4'h0);
		wait_cycle();
		`CHK({o_copy_busy, o_copy_mode}, {1'b1, cmg_pkg::CMG_MODE_FW});
		u_cpu.fire(IRQ, 16'h0000, 4'h0);
		`CHK({o_mode, o_copy_mode}, {cmg_pkg::CMG_MODE_SYS, cmg_pkg::CMG_MODE_FW});
		u_cpu.fire(CDN, 16'h0000, 4'h0);
		wait_cycle();
		`CHK(o_copy_busy, 1'b0);
		$display("test firmware_and_copy done");
		// Second reset mid-run, then the permanent feature path from test mode
		do_reset();
		`CHK(o_stbl_base, 16'h0000);
		u_cpu.fire(TEST, 16'h0000, 4'h0);
		`CHK(o_mode, cmg_pkg::CMG_MODE_TEST);
		u_cpu.fire(PERM, 16'h0000, 4'h8);
		wait_cycle();
		`CHK(o_feat_en, 4'h7);
		u_cpu.sfr_write(HI, 8'h77);
		`CHK(o_sfr_deny, 1'b1);
		`CHK(o_stbl_base, 16'h0000);
		// With the table base still zero no user access may pass
		u_cpu.sfr_write(CSR, 8'(cmg_pkg::CMG_CSR_USER));
		`CHK(o_mode, cmg_pkg::CMG_MODE_USER);
		u_cpu.mem_access(4'b0011, 16'h1000);
		`CHK({o_mem_grant, o_mem_deny}, 2'b01);
		$display("test permanent_features done");
		complete_run();
	end
endmodule : cmg_access_guard_tb_top
